// file: sto_pkg.sv
// Purpose: constants and carrier types for the torque-off supervisor
// Assumes: 40 MHz system clock
// Notes: one package shared by the design file and the bench
// Function
// - energised input: standby, start from selected source
// - de-energised input: coast stop, torque-off mode
// - no-torque output within 1 ms
// - monitoring status changes within 20 ms
// - channel fault shown, not-healthy within 20 ms
// - display inhibit unless tripped, then trip
// - relay one opens at setting 13
// - relay two opens at setting 13
// - channel fault raises code 29
// - supervision never disabled by settings
// - edge mode starts only on run rising edge
// - start mode defaults to auto restart
package sto_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned STATUS_MAX_MS = 20;
  localparam int unsigned DISAGREE_US = 1000;
  localparam int unsigned DISAGREE_CYC = DISAGREE_US * (CLK_HZ / 1000000);
  localparam int unsigned CNT_W = 16;
  // ---------------------------------------------------------------
  // codes and settings
  // ---------------------------------------------------------------
  localparam logic [7:0] RELAY_FN_STO = 8'h0d;
  localparam logic [7:0] FAULT_CODE_CHAN = 8'h1d;
  localparam logic [7:0] FAULT_CODE_NONE = 8'h00;
  localparam logic [1:0] SRC_TERMINAL = 2'h0;
  localparam logic [1:0] SRC_KEYPAD = 2'h1;
  localparam logic [1:0] SRC_FIELDBUS = 2'h2;
  localparam logic START_MODE_AUTO = 1'b0;
  localparam logic START_MODE_EDGE = 1'b1;

  typedef enum logic [1:0] {
    ST_INHIBIT = 2'b00,
    ST_STANDBY = 2'b01,
    ST_RUN = 2'b10
  } sto_state_t;

  typedef enum logic [1:0] {
    DSP_NORMAL = 2'b00,
    DSP_INHIBIT = 2'b01,
    DSP_TRIP = 2'b10
  } sto_disp_t;

  typedef struct packed {
    logic [1:0] ch_meta;
    logic [1:0] ch_sync;
    logic run_prev;
    logic fault;
    logic [CNT_W-1:0] dis_cnt;
    sto_state_t state;
    logic healthy;
    sto_disp_t disp;
    logic [7:0] code;
  } sto_st_t;

  typedef struct packed {
    logic [1:0] start_source_select;
    logic start_mode_select;
    logic [7:0] relay_one_function_select;
    logic [7:0] relay_two_function_select;
  } sto_cfg_t;
endpackage

// file: sto_supervisor.sv
// Purpose: two-channel torque-off input supervisor
// Assumes: channel inputs asynchronous, high when energised
// Notes: all state in one struct; clock enable freezes it
`timescale 1ns/1ps
module sto_supervisor (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  input wire logic [1:0] sto_ch_i,
  input wire logic [1:0] start_source_select_i,
  input wire logic start_mode_select_i,
  input wire logic [7:0] relay_one_function_select_i,
  input wire logic [7:0] relay_two_function_select_i,
  input wire logic run_terminal_i,
  input wire logic run_keypad_i,
  input wire logic run_fieldbus_i,
  input wire logic trip_i,
  input wire logic [7:0] trip_code_i,
  input wire logic fault_reset_i,
  output logic gate_enable_o,
  output logic sto_active_o,
  output logic healthy_o,
  output logic relay_one_closed_o,
  output logic relay_two_closed_o,
  output logic [1:0] display_o,
  output logic [7:0] fault_code_o
);
  sto_pkg::sto_st_t st_reg;
  sto_pkg::sto_st_t st_next;
  sto_pkg::sto_cfg_t cfg;
  logic run_cmd;
  logic both_on;
  logic any_off;
  logic run_edge;
  localparam int unsigned N_RELAY = 2;
  logic [7:0] relay_sel [N_RELAY];
  logic [N_RELAY-1:0] relay_closed;
  // reset image: torque off, healthy, inhibit shown, no code
  localparam sto_pkg::sto_st_t ST_RESET = '{
    ch_meta: '0,
    ch_sync: '0,
    run_prev: 1'b0,
    fault: 1'b0,
    dis_cnt: '0,
    state: sto_pkg::ST_INHIBIT,
    healthy: 1'b1,
    disp: sto_pkg::DSP_INHIBIT,
    code: sto_pkg::FAULT_CODE_NONE
  };

  // ---------------------------------------------------------------
  // config carrier and run source
  // ---------------------------------------------------------------
  always_comb begin
    cfg.start_source_select = start_source_select_i;
    cfg.start_mode_select = start_mode_select_i;
    cfg.relay_one_function_select = relay_one_function_select_i;
    cfg.relay_two_function_select = relay_two_function_select_i;
    unique case (cfg.start_source_select)
      sto_pkg::SRC_TERMINAL: run_cmd = run_terminal_i;
      sto_pkg::SRC_KEYPAD: run_cmd = run_keypad_i;
      sto_pkg::SRC_FIELDBUS: run_cmd = run_fieldbus_i;
      default: run_cmd = 1'b0;
    endcase
  end

  assign both_on = &st_reg.ch_sync;
  assign any_off = ~both_on;
  assign run_edge = run_cmd & ~st_reg.run_prev;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.ch_meta = sto_ch_i;
    st_next.ch_sync = st_reg.ch_meta;
    st_next.run_prev = run_cmd;
    // disagreement filter; fault latches until reset with channels agreeing
    if (st_reg.ch_sync[0] != st_reg.ch_sync[1]) begin
      if (st_reg.dis_cnt >= sto_pkg::CNT_W'(sto_pkg::DISAGREE_CYC - 1)) begin
        st_next.fault = 1'b1;
      end else begin
        st_next.dis_cnt = st_reg.dis_cnt + 1'b1;
      end
    end else begin
      st_next.dis_cnt = '0;
      if (fault_reset_i) begin
        st_next.fault = 1'b0;
      end
    end
    // no setting input reaches the drop to inhibit, so supervision cannot be disabled
    unique case (st_reg.state)
      sto_pkg::ST_INHIBIT: begin
        if (both_on) begin
          st_next.state = sto_pkg::ST_STANDBY;
        end
      end
      sto_pkg::ST_STANDBY: begin
        if (any_off) begin
          st_next.state = sto_pkg::ST_INHIBIT;
        end else if (!trip_i && !st_reg.fault) begin
          if (cfg.start_mode_select == sto_pkg::START_MODE_EDGE) begin
            if (run_edge) begin
              st_next.state = sto_pkg::ST_RUN;
            end
          end else if (run_cmd) begin
            st_next.state = sto_pkg::ST_RUN;
          end
        end
      end
      sto_pkg::ST_RUN: begin
        if (any_off) begin
          st_next.state = sto_pkg::ST_INHIBIT;
        end else if (!run_cmd || trip_i || st_reg.fault) begin
          st_next.state = sto_pkg::ST_STANDBY;
        end
      end
      default: st_next.state = sto_pkg::ST_INHIBIT;
    endcase
    // report fields follow the next state, so display never lags the mode outputs
    st_next.healthy = ~st_next.fault & ~trip_i;
    if (st_next.fault) begin
      st_next.disp = sto_pkg::DSP_TRIP;
      st_next.code = sto_pkg::FAULT_CODE_CHAN;
    end else if (trip_i) begin
      st_next.disp = sto_pkg::DSP_TRIP;
      st_next.code = trip_code_i;
    end else if (st_next.state == sto_pkg::ST_INHIBIT) begin
      st_next.disp = sto_pkg::DSP_INHIBIT;
      st_next.code = sto_pkg::FAULT_CODE_NONE;
    end else begin
      st_next.disp = sto_pkg::DSP_NORMAL;
      st_next.code = sto_pkg::FAULT_CODE_NONE;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_reg <= ST_RESET;
    end else if (clk_en_i) begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // gate enable follows the state register: 3 cycles from pin, far under 1 ms
  assign gate_enable_o = (st_reg.state == sto_pkg::ST_RUN);
  assign sto_active_o = (st_reg.state == sto_pkg::ST_INHIBIT);
  assign healthy_o = st_reg.healthy;
  assign display_o = st_reg.disp;
  assign fault_code_o = st_reg.code;

  // ---------------------------------------------------------------
  // relay drivers
  // ---------------------------------------------------------------
  // a relay given any other function stays closed here; that function lives elsewhere
  assign relay_sel[0] = cfg.relay_one_function_select;
  assign relay_sel[1] = cfg.relay_two_function_select;
  for (genvar r = 0; r < N_RELAY; r++) begin : g_relay
    assign relay_closed[r] =
      (relay_sel[r] == sto_pkg::RELAY_FN_STO) ? ~sto_active_o : 1'b1;
  end
  assign relay_one_closed_o = relay_closed[0];
  assign relay_two_closed_o = relay_closed[1];
endmodule // sto_supervisor

// file: sto_relay_model.sv
// Purpose: safety relay feeding both torque-off channels
// Assumes: both contacts move together while split is low
// Notes: split holds one contact open
`timescale 1ns/1ps
module sto_relay_model (
  input wire logic energise_i,
  input wire logic split_i,
  output logic [1:0] sto_ch_o
);
  assign sto_ch_o = {energise_i, energise_i & ~split_i};
endmodule // sto_relay_model

// file: sto_supervisor_props.sv
// Purpose: port checks of the torque-off supervisor
// Assumes: clock enable held high
// Notes: bound below
`timescale 1ns/1ps
module sto_supervisor_props (
  input logic sys_clk_i,
  input logic resetn_i,
  input logic [1:0] sto_ch_i,
  input logic [1:0] start_source_select_i,
  input logic start_mode_select_i,
  input logic [7:0] relay_one_function_select_i,
  input logic [7:0] relay_two_function_select_i,
  input logic run_terminal_i,
  input logic trip_i,
  input logic gate_enable_o,
  input logic sto_active_o,
  input logic healthy_o,
  input logic relay_one_closed_o,
  input logic relay_two_closed_o,
  input logic [1:0] display_o,
  input logic [7:0] fault_code_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_held;
    (start_mode_select_i && run_terminal_i && start_source_select_i == 2'h0)[*2]
      ##0 !gate_enable_o;
  endsequence
  a_off_nogate: assert property (sto_active_o |-> !gate_enable_o)
    else $error("gate on");
  a_drop_fast: assert property (!(&sto_ch_i) |-> ##[1:3] sto_active_o)
    else $error("late off");
  a_relay_one: assert property (relay_one_closed_o ==
    !(relay_one_function_select_i == 8'h0d && sto_active_o)) else $error("relay one");
  a_relay_two: assert property (relay_two_closed_o ==
    !(relay_two_function_select_i == 8'h0d && sto_active_o)) else $error("relay two");
  a_disp_inh: assert property (sto_active_o && healthy_o |-> display_o == 2'h1)
    else $error("no inhibit");
  a_disp_trip: assert property (!healthy_o |-> display_o == 2'h2)
    else $error("no trip");
  // report outputs are registered, so they carry the trip level of the cycle before
  a_chan_code: assert property (!healthy_o && !$past(trip_i) |-> fault_code_o == 8'h1d)
    else $error("bad code");
  a_trip_flag: assert property (trip_i |=> !healthy_o)
    else $error("trip healthy");
  a_edge_hold: assert property (s_held |=> !gate_enable_o)
    else $error("held run");
endmodule // sto_supervisor_props
bind sto_supervisor sto_supervisor_props props_u (.*);

// file: sto_supervisor_bench.sv
// Purpose: self-checking bench of the torque-off supervisor
// Assumes: 40 MHz clock
// Notes: filter is a package constant, so one long wait
`timescale 1ns/1ps
module sto_supervisor_bench;
  logic clk = '0, rst_n = '0, en = '0, spl = '0, mode = '0, trip = '0, frst = '0;
  logic gate, act, hl, r1, r2;
  logic [1:0] src = '0, ch, dsp;
  logic [2:0] run = '0;
  logic [7:0] rs = 8'h0d, code;
  logic [5:0] rows [5] = '{6'h03, 6'h15, 6'h29, 6'h3e, 6'h0c};
  int n_fail = 0, n_compared = 0, cyc = 0;
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc > 45000) begin
      n_fail++;
      report_and_stop();
    end
  end
  sto_relay_model rel_u (.energise_i(en), .split_i(spl), .sto_ch_o(ch));
  sto_supervisor dut_u (.sys_clk_i(clk), .resetn_i(rst_n), .clk_en_i(1'h1), .sto_ch_i(ch),
    .start_source_select_i(src), .start_mode_select_i(mode), .run_terminal_i(run[0]),
    .relay_one_function_select_i(rs), .relay_two_function_select_i(rs ^ 8'h0d),
    .run_keypad_i(run[1]), .run_fieldbus_i(run[2]), .trip_i(trip), .trip_code_i(8'h07),
    .fault_reset_i(frst), .gate_enable_o(gate), .sto_active_o(act), .healthy_o(hl),
    .relay_one_closed_o(r1), .relay_two_closed_o(r2), .display_o(dsp), .fault_code_o(code));
  // ---------------------------------------------------------------
  // compare tasks, one per kind of result
  // ---------------------------------------------------------------
  task automatic chk_bit(logic a, logic e);
    n_compared++;
    if (a !== e) begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, a, e);
    end
  endtask
  task automatic chk_dsp(logic [1:0] a, logic [1:0] e);
    n_compared++;
    if (a !== e) begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, a, e);
    end
  endtask
  task automatic chk_code(logic [7:0] a, logic [7:0] e);
    n_compared++;
    if (a !== e) begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, a, e);
    end
  endtask
  // checks fall on the falling edge, after flops settle
  task automatic tk(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic report_and_stop();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    tk(12);
    chk_bit(act, 1'b1);
    chk_bit(gate, 1'b0);
    chk_bit(r1, 1'b0);
    chk_bit(r2, 1'b1);
    $display("reset end");
    @(posedge clk) begin
      rst_n <= 1'b1;
      en <= 1'b1;
    end
    tk(6);
    foreach (rows[i]) begin
      @(posedge clk) begin
        src <= rows[i][5:4];
        run <= rows[i][3:1];
      end
      tk(4);
      chk_bit(gate, rows[i][0]);
      @(posedge clk) run <= '0;
      tk(3);
    end
    $display("rows end");
    @(posedge clk) begin
      mode <= 1'b1;
      en <= 1'b0;
    end
    tk(4);
    chk_bit(act, 1'b1);
    chk_dsp(dsp, 2'h1);
    @(posedge clk) run <= 3'h1;
    tk(2);
    @(posedge clk) en <= 1'b1;
    tk(8);
    chk_bit(gate, 1'b0);
    @(posedge clk) run <= '0;
    tk(2);
    @(posedge clk) run <= 3'h1;
    tk(3);
    chk_bit(gate, 1'b1);
    $display("edge end");
    @(posedge clk) begin
      mode <= 1'b0;
      rs <= 8'h00;
      en <= 1'b0;
    end
    tk(4);
    chk_bit(gate, 1'b0);
    chk_bit(act, 1'b1);
    chk_bit(r2, 1'b0);
    chk_bit(r1, 1'b1);
    @(posedge clk) trip <= 1'b1;
    tk(2);
    chk_dsp(dsp, 2'h2);
    chk_code(code, 8'h07);
    chk_bit(hl, 1'b0);
    @(posedge clk) begin
      trip <= 1'b0;
      en <= 1'b1;
    end
    tk(6);
    chk_bit(gate, 1'b1);
    $display("drop end");
    @(posedge clk) spl <= 1'b1;
    // just before the filter runs out the split must still look healthy
    tk(sto_pkg::DISAGREE_CYC);
    chk_bit(hl, 1'b1);
    chk_dsp(dsp, 2'h1);
    tk(10);
    chk_code(code, 8'h1d);
    chk_bit(hl, 1'b0);
    chk_dsp(dsp, 2'h2);
    chk_bit(gate, 1'b0);
    @(posedge clk) begin
      spl <= 1'b0;
      frst <= 1'b1;
    end
    tk(4);
    chk_bit(hl, 1'b1);
    chk_code(code, 8'h00);
    $display("fault end");
    @(posedge clk) rst_n <= 1'b0;
    tk(2);
    chk_bit(gate, 1'b0);
    chk_bit(act, 1'b1);
    chk_dsp(dsp, 2'h1);
    chk_code(code, 8'h00);
    @(posedge clk) rst_n <= 1'b1;
    tk(3);
    chk_bit(gate, 1'b0);
    tk(2);
    chk_bit(gate, 1'b1);
    $display("reset mid end");
    report_and_stop();
  end
endmodule // sto_supervisor_bench
